// *** rtl/sbsp_pkg.sv ***
// constants, states and carriers of the two-wire bus slave port
// assumes one register index space of 8 bits and 8-bit data
package sbsp_pkg;

    localparam int BYTE_BITS = 8;
    localparam logic [3:0] ADDR_PREFIX = 4'h5;
    localparam int ADDR_LO_BITS = 3;
    localparam logic [1:0] MAX_WR_BYTES = 2'h2;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] ADDR_LO_RESET = 3'h0;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK
    } sbsp_state_t;

    typedef struct packed {
        logic [7:0] ptr;
        logic [7:0] data;
    } sbsp_xfer_t;

endpackage

// *** rtl/sbsp_sync.sv ***
// two-flop level synchroniser, one bit per lane
// assumes each lane is a level that stays put for several dest clocks
`timescale 1ns/1ps
module sbsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            dout <= '0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// *** rtl/sbsp_strap.sv ***
// one-shot capture of the address strap conversion result
// assumes the converter reports its first result with a one-cycle pulse
`timescale 1ns/1ps
module sbsp_strap (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] code,
    input wire logic done,
    output logic [2:0] addr_lo,
    output logic locked
);

    // later conversions are ignored until the next power-up reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_lo <= sbsp_pkg::ADDR_LO_RESET;
            locked <= 1'b0;
        end
        else if (done && !locked)
        begin
            addr_lo <= code;
            locked <= 1'b1;
        end
    end

endmodule

// *** rtl/sbsp_top.sv ***
// two-wire bus slave port: bus engine on LINK_CLK, register side on CLK
// assumes SCL and SDA are open-drain pins resolved outside, SCL from master
// Behaviour
// - The port is a slave only and every transfer is clocked by the master.
// - The port answers to a 7-bit address whose upper four bits are 0101.
// - The low address bits come from one strap conversion at power-up.
// - The captured address is kept and later strap changes are ignored.
// - Each byte is eight data bits plus an acknowledge by the receiver.
// - Data moves only with clock low; a data rise with clock high is a stop.
// - Direction is set at the start and changes only with a new operation.
// - Direction bit 1 means read from the slave, 0 means write to it.
// - A write carries one or two data bytes and a read supplies one byte.
// - The register pointer is loaded by the first byte of a write.
`timescale 1ns/1ps
module sbsp_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic LINK_CLK,
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE,
    input wire logic [2:0] ADC_CODE,
    input wire logic ADC_DONE,
    output logic ADDR_LOCKED,
    output logic [7:0] REG_ADDR,
    output logic [7:0] REG_WDATA,
    output logic REG_WR,
    output logic REG_RD,
    input wire logic [7:0] REG_RDATA
);

    function automatic logic addr_match(input logic [6:0] rx,
                                        input logic [2:0] lo);
        addr_match = (rx == {sbsp_pkg::ADDR_PREFIX, lo});
    endfunction

    // register side, CLK domain
    logic [2:0] addr_lo;
    logic wr_seen;
    logic rd_seen;
    logic [7:0] rd_hold;
    logic rd_ack_tgl;
    logic wr_tgl;
    logic rd_tgl;
    logic wr_tgl_s;
    logic rd_tgl_s;
    logic wr_seen_q;
    logic rd_seen_q;
    sbsp_pkg::sbsp_xfer_t xfer;

    sbsp_strap u_strap (
        .clk(CLK),
        .rst_n(RST_N),
        .code(ADC_CODE),
        .done(ADC_DONE),
        .addr_lo(addr_lo),
        .locked(ADDR_LOCKED)
    );

    sbsp_sync #(.WIDTH(2)) u_req_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .din({wr_tgl, rd_tgl}),
        .dout({wr_tgl_s, rd_tgl_s})
    );

    // toggles carry events; xfer words stay frozen while a toggle is seen
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            wr_seen_q <= 1'b0;
            rd_seen_q <= 1'b0;
        end
        else
        begin
            wr_seen_q <= wr_tgl_s;
            rd_seen_q <= rd_tgl_s;
        end
    end

    assign wr_seen = wr_tgl_s ^ wr_seen_q;
    assign rd_seen = rd_tgl_s ^ rd_seen_q;

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            REG_WR <= 1'b0;
            REG_RD <= 1'b0;
            REG_ADDR <= sbsp_pkg::PTR_RESET;
            REG_WDATA <= sbsp_pkg::DATA_RESET;
        end
        else
        begin
            REG_WR <= wr_seen;
            REG_RD <= rd_seen;
            if (wr_seen || rd_seen)
            begin
                REG_ADDR <= xfer.ptr;
                REG_WDATA <= xfer.data;
            end
        end
    end

    // read data is caught in the strobe cycle, then handed back
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rd_hold <= sbsp_pkg::IDLE_BYTE;
            rd_ack_tgl <= 1'b0;
        end
        else if (REG_RD)
        begin
            rd_hold <= REG_RDATA;
            rd_ack_tgl <= ~rd_ack_tgl;
        end
    end

    // bus side, LINK_CLK domain
    logic scl_s;
    logic sda_s;
    logic scl_q;
    logic sda_q;
    logic locked_s;
    logic ack_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic is_read;
    logic [1:0] nbytes;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    sbsp_pkg::sbsp_state_t state;

    sbsp_sync #(.WIDTH(4)) u_link_sync (
        .clk(LINK_CLK),
        .rst_n(RST_N),
        .din({SCL_I, SDA_I, ADDR_LOCKED, rd_ack_tgl}),
        .dout({scl_s, sda_s, locked_s, ack_s})
    );

    always_ff @(posedge LINK_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s;
            sda_q <= sda_s;
        end
    end

    // the master owns the clock; the port only watches its edges
    assign scl_rise = scl_s && !scl_q;
    assign scl_fall = !scl_s && scl_q;
    assign start_seen = scl_s && scl_q && sda_q && !sda_s;
    assign stop_seen = scl_s && scl_q && !sda_q && sda_s;

    assign SDA_O = 1'b0;

    always_ff @(posedge LINK_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state <= sbsp_pkg::ST_IDLE;
            cnt <= 4'h0;
            shift <= 8'h00;
            tx <= sbsp_pkg::IDLE_BYTE;
            SDA_OE <= 1'b0;
            is_read <= 1'b0;
            nbytes <= 2'h0;
            wr_tgl <= 1'b0;
            rd_tgl <= 1'b0;
            xfer <= '0;
        end
        else if (start_seen)
        begin
            state <= sbsp_pkg::ST_ADDR;
            cnt <= 4'h0;
            nbytes <= 2'h0;
            SDA_OE <= 1'b0;
        end
        else if (stop_seen)
        begin
            state <= sbsp_pkg::ST_IDLE;
            SDA_OE <= 1'b0;
        end
        else if (scl_rise)
        begin
            // bits are taken on the rising clock edge only
            unique case (state)
                sbsp_pkg::ST_ADDR, sbsp_pkg::ST_WR_BYTE:
                begin
                    shift <= {shift[6:0], sda_s};
                    cnt <= cnt + 4'h1;
                end
                sbsp_pkg::ST_RD_BYTE:
                begin
                    cnt <= cnt + 4'h1;
                end
                default:
                begin
                end
            endcase
        end
        else if (scl_fall)
        begin
            // outputs change only just after the clock falls
            unique case (state)
                sbsp_pkg::ST_IDLE:
                begin
                    SDA_OE <= 1'b0;
                end
                sbsp_pkg::ST_ADDR:
                begin
                    if (cnt == sbsp_pkg::BIT_LAST)
                    begin
                        if (locked_s && addr_match(shift[7:1], addr_lo))
                        begin
                            SDA_OE <= 1'b1;
                            state <= sbsp_pkg::ST_ADDR_ACK;
                            is_read <= shift[0];
                            if (shift[0])
                            begin
                                rd_tgl <= ~rd_tgl;
                            end
                        end
                        else
                        begin
                            state <= sbsp_pkg::ST_IDLE;
                        end
                    end
                end
                sbsp_pkg::ST_ADDR_ACK:
                begin
                    cnt <= 4'h0;
                    if (is_read)
                    begin
                        // not yet fetched: idle byte goes out instead
                        tx <= (ack_s == rd_tgl) ? rd_hold
                                                : sbsp_pkg::IDLE_BYTE;
                        SDA_OE <= (ack_s == rd_tgl) ? ~rd_hold[7] : 1'b0;
                        state <= sbsp_pkg::ST_RD_BYTE;
                    end
                    else
                    begin
                        SDA_OE <= 1'b0;
                        state <= sbsp_pkg::ST_WR_BYTE;
                    end
                end
                sbsp_pkg::ST_WR_BYTE:
                begin
                    if (cnt == sbsp_pkg::BIT_LAST)
                    begin
                        if (nbytes < sbsp_pkg::MAX_WR_BYTES)
                        begin
                            SDA_OE <= 1'b1;
                            nbytes <= nbytes + 2'h1;
                            state <= sbsp_pkg::ST_WR_ACK;
                            if (nbytes == 2'h0)
                            begin
                                xfer.ptr <= shift;
                            end
                            else
                            begin
                                xfer.data <= shift;
                                wr_tgl <= ~wr_tgl;
                            end
                        end
                        else
                        begin
                            state <= sbsp_pkg::ST_IDLE;
                        end
                    end
                end
                sbsp_pkg::ST_WR_ACK:
                begin
                    SDA_OE <= 1'b0;
                    cnt <= 4'h0;
                    state <= sbsp_pkg::ST_WR_BYTE;
                end
                sbsp_pkg::ST_RD_BYTE:
                begin
                    if (cnt == sbsp_pkg::BIT_LAST)
                    begin
                        SDA_OE <= 1'b0;
                        state <= sbsp_pkg::ST_RD_ACK;
                    end
                    else
                    begin
                        tx <= {tx[6:0], 1'b1};
                        SDA_OE <= ~tx[6];
                    end
                end
                sbsp_pkg::ST_RD_ACK:
                begin
                    // one byte per read, whatever the master answered
                    SDA_OE <= 1'b0;
                    state <= sbsp_pkg::ST_IDLE;
                end
                default:
                begin
                    state <= sbsp_pkg::ST_IDLE;
                end
            endcase
        end
    end

endmodule

// *** test/sbsp_top_props.sv ***
// pin-level assertions for the two-wire slave port
// assumes bound to sbsp_top; both clocks run during checks
`timescale 1ns/1ps
module sbsp_top_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic LINK_CLK,
    input wire logic SCL_I,
    input wire logic SDA_O,
    input wire logic SDA_OE,
    input wire logic ADC_DONE,
    input wire logic ADDR_LOCKED,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD
);
    chk_drive_zero:
    assert property (@(posedge LINK_CLK) disable iff (!RST_N) !SDA_O)
        else $error("data output not low");
    chk_oe_scl_low:
    assert property (@(posedge LINK_CLK) disable iff (!RST_N)
        $changed(SDA_OE) |-> !SCL_I) else $error("data moved, clock high");
    chk_no_ack_unlocked:
    assert property (@(posedge LINK_CLK) disable iff (!RST_N)
        !ADDR_LOCKED |-> !SDA_OE) else $error("driven before lock");
    chk_lock_kept:
    assert property (@(posedge CLK) disable iff (!RST_N)
        ADDR_LOCKED |=> ADDR_LOCKED) else $error("lock lost");
    chk_lock_cause:
    assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(ADDR_LOCKED) |-> $past(ADC_DONE)) else $error("lock uncaused");
    chk_wr_single:
    assert property (@(posedge CLK) disable iff (!RST_N)
        REG_WR |=> !REG_WR [*8]) else $error("write strobe too long");
    chk_rd_single:
    assert property (@(posedge CLK) disable iff (!RST_N)
        REG_RD |=> !REG_RD [*8]) else $error("read strobe too long");
    chk_dir_excl:
    assert property (@(posedge CLK) disable iff (!RST_N)
        !(REG_WR && REG_RD)) else $error("read and write together");
    chk_ptr_hold:
    assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(REG_ADDR) |-> REG_WR || REG_RD) else $error("pointer moved");
    chk_wdata_hold:
    assert property (@(posedge CLK) disable iff (!RST_N)
        $changed(REG_WDATA) |-> REG_WR) else $error("write data moved");
    cov_wr: cover property (@(posedge CLK) REG_WR);
    cov_rd: cover property (@(posedge CLK) REG_RD);
    cov_ack: cover property (@(posedge LINK_CLK) $rose(SDA_OE));
endmodule
bind sbsp_top sbsp_top_props i_sbsp_top_props (.CLK, .RST_N, .LINK_CLK,
    .SCL_I, .SDA_O, .SDA_OE, .ADC_DONE, .ADDR_LOCKED, .REG_ADDR,
    .REG_WDATA, .REG_WR, .REG_RD);

// *** test/sbsp_master.sv ***
// behavioural two-wire bus master facing the slave port
// assumes the bench resolves the data line with a pull-up
`timescale 1ns/1ps
module sbsp_master #(
    parameter int HALF = 800
) (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // clock idles high, stands still outside frames
    initial
    begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic start;
        sda_low = 1'h0;
        #(HALF) scl = 1'h1;
        #(HALF) sda_low = 1'h1;
        #(HALF) scl = 1'h0;
    endtask
    // data moves mid-low so hold time is kept
    task automatic bit_io(input logic b, output logic r);
        #(HALF/2) sda_low = !b;
        #(HALF/2) scl = 1'h1;
        #(HALF/2) r = sda;
        #(HALF/2) scl = 1'h0;
    endtask
    task automatic byte_io(input logic [7:0] tx, input logic last,
        output logic [7:0] rx, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(tx[i], r);
            rx[i] = r;
        end
        bit_io(last, ack);
    endtask
    task automatic stop;
        #(HALF/2) sda_low = 1'h1;
        #(HALF/2) scl = 1'h1;
        #(HALF) sda_low = 1'h0;
        #(HALF);
    endtask
endmodule

// *** test/sbsp_top_tb.sv ***
// self-checking bench for the two-wire slave port
// assumes strap code 5, so the port answers at 0x2d
`timescale 1ns/1ps
module sbsp_top_tb;
    logic clk = 1'h0;
    logic link_clk = 1'h0;
    logic rst_n = 1'h0;
    logic adc_done = 1'h0;
    logic [2:0] adc_code = 3'h0;
    logic scl, m_low, sda_o, sda_oe, locked, reg_wr, reg_rd, ack;
    logic [7:0] reg_addr, reg_wdata, wr_a, wr_d, rx;
    int failures = 0;
    int total_checks = 0;
    int wr_cnt = 0;
    int rd_cnt = 0;
    wire sda = !((sda_oe && !sda_o) || m_low);
    wire [7:0] reg_rdata = reg_addr ^ 8'h3c;
    initial forever #5 clk = !clk;
    initial
    begin
        #7;
        forever #16 link_clk = !link_clk;
    end
    always @(posedge clk)
    begin
        if (reg_wr)
        begin
            wr_cnt++;
            wr_a = reg_addr;
            wr_d = reg_wdata;
        end
        if (reg_rd)
            rd_cnt++;
    end
    sbsp_master i_sbsp_master (.scl(scl), .sda_low(m_low), .sda(sda));
    sbsp_top i_sbsp_top (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk),
        .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
        .ADC_CODE(adc_code), .ADC_DONE(adc_done), .ADDR_LOCKED(locked),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic put(input logic [7:0] v, input logic exp_ack);
        i_sbsp_master.byte_io(v, 1'h1, rx, ack);
        check({7'h0, ack}, {7'h0, exp_ack});
    endtask
    task automatic test_strap;
        int k;
        adc_code = 3'h5;
        adc_done = 1'h1;
        @(negedge clk);
        adc_done = 1'h0;
        adc_code = 3'h2;
        for (k = 0; k < 20 && locked !== 1'h1; k++) @(negedge clk);
        check({7'h0, locked}, 8'h01);
        if (locked !== 1'h1)
            conclude;
        // a later result must not move the address
        adc_done = 1'h1;
        @(negedge clk);
        adc_done = 1'h0;
        #200;
        $display("test strap done");
    endtask
    task automatic test_write;
        i_sbsp_master.start();
        put(8'h5a, 1'h0);
        put(8'h31, 1'h0);
        put(8'ha7, 1'h0);
        i_sbsp_master.stop();
        check(wr_cnt[7:0], 8'h01);
        check(wr_a, 8'h31);
        check(wr_d, 8'ha7);
        $display("test write done");
    endtask
    task automatic test_read;
        i_sbsp_master.start();
        put(8'h5b, 1'h0);
        i_sbsp_master.byte_io(8'hff, 1'h1, rx, ack);
        i_sbsp_master.stop();
        check(rx, 8'h0d);
        check(rd_cnt[7:0], 8'h01);
        $display("test read done");
    endtask
    // pointer-only write, then repeated start turns to read
    task automatic test_repeat;
        i_sbsp_master.start();
        put(8'h5a, 1'h0);
        put(8'h06, 1'h0);
        i_sbsp_master.start();
        put(8'h5b, 1'h0);
        i_sbsp_master.byte_io(8'hff, 1'h1, rx, ack);
        i_sbsp_master.stop();
        check(rx, 8'h3a);
        check(wr_cnt[7:0], 8'h01);
        $display("test repeat done");
    endtask
    task automatic test_third;
        i_sbsp_master.start();
        put(8'h5a, 1'h0);
        put(8'h40, 1'h0);
        put(8'h11, 1'h0);
        put(8'h22, 1'h1);
        i_sbsp_master.stop();
        check(wr_cnt[7:0], 8'h02);
        check(wr_d, 8'h11);
        check(wr_a, 8'h40);
        $display("test third done");
    endtask
    // later strap code as a read, wrong prefix, wrong low bits
    task automatic test_foreign;
        logic [7:0] addrs [3] = '{8'h55, 8'h7a, 8'h5c};
        foreach (addrs[i])
        begin
            i_sbsp_master.start();
            put(addrs[i], 1'h1);
            put(8'h00, 1'h1);
            i_sbsp_master.stop();
        end
        check(wr_cnt[7:0], 8'h02);
        check(rd_cnt[7:0], 8'h02);
        $display("test foreign done");
    endtask
    initial
    begin
        repeat (6) @(negedge clk);
        rst_n = 1'h1;
        @(negedge clk);
        test_strap;
        test_write;
        test_read;
        test_repeat;
        test_third;
        test_foreign;
        conclude;
    end
endmodule
